/* File: hdl/adc_conversion_sequencer.sv */
/*
  digital control of a 12-bit successive approximation converter: control and
  result registers, start pulse detection, sample/convert sequencing, completion
  flag and interrupt, analog steering outputs, and the calibration option memory.
  assumes the analog core presents a settled code on ADC_CODE_I at the end of
  the last convert period, and a single system clock for everything.
*/
// Decided for this implementation: strobed register access and the register offsets.
// How it works
// - non-temperature inputs sample 4 conversion clocks, convert 12, total 16.
// - temperature sensor input samples 46 conversion clocks, converts 12, total 58.
// - start bit low, high, low launches a conversion on the final fall.
// - in-progress flag high during conversion; result bytes valid once it drops.
// - clearing power-on turns the converter core off regardless of input.
// - result is a 12-bit code, one step equals reference over 4096.
// - alignment bit picks how the 12-bit result splits across two bytes.
// - second-point temperature code held at 3FF5H, 0.2C per step.
// - second-point code bits 11..4 at 3FF6H, bits 3..0 at 3FF7H.
// - option memory readable on last page only while mapping enabled.
// - start sets in-progress; completion sets the flag and interrupts if enabled.
// - divider field gives system clock over two to the field value.
// - external sources route codes 0-3 and 5-8 to pins; 12-15 float.
// - reference 01/11 analog supply, 10 temperature reference, 00 reference pin.
`timescale 1ns/100ps
module adc_conversion_sequencer #(
  parameter logic [7:0] CAL_HIGH = 8'h00, // arbitrary factory value
  parameter logic [7:0] CAL_LOW = 8'h00, // arbitrary factory value
  parameter logic [7:0] T2_CODE = 8'h00, // arbitrary factory value
  parameter logic [11:0] ADC2_CODE = 12'h000 // arbitrary factory value
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // interrupt
  output logic IRQ_O,
  // analog core
  input wire logic [adc_seq_pkg::RESULT_WIDTH-1:0] ADC_CODE_I,
  output logic ADC_POWER_O,
  output logic SAMPLE_O,
  output logic CONVERT_O,
  output logic [2:0] INPUT_SRC_O,
  output logic [adc_seq_pkg::PIN_COUNT-1:0] PIN_SEL_O,
  output logic [2:0] REF_SEL_O,
  output logic TEMP_SENSOR_EN_O,
  // program memory table read of the option page
  input wire logic TBL_RD_I,
  input wire logic [13:0] TBL_ADDR_I,
  output logic [7:0] TBL_DATA_O,
  output logic TBL_HIT_O
);
  import adc_seq_pkg::*;

  adc_clk_if clk_if ();

  seq_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [3:0] ch_r, ch_nxt;
  logic align_r, align_nxt;
  logic power_r, power_nxt;
  logic start_r, start_nxt;
  logic [2:0] src_r, src_nxt;
  logic [1:0] ref_r, ref_nxt;
  logic [2:0] div_r, div_nxt;
  logic gie_r, gie_nxt;
  logic cie_r, cie_nxt;
  logic flag_r, flag_nxt;
  logic temp_sensor_power_r, temp_sensor_power_nxt;
  logic option_map_control_r, option_map_control_nxt;
  logic [11:0] result_r, result_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [8:0] pin_r, pin_nxt;
  logic [2:0] refsel_r, refsel_nxt;
  logic [7:0] tbl_r, tbl_nxt;
  logic hit_r, hit_nxt;
  logic wr_first, wr_second, wr_irq;
  logic start_fall, start_rise, done;
  logic [5:0] sample_last;
  logic [7:0] res_high, res_low;
  logic [7:0] opt_mem [0:2];

  // divider connection: runs from the launching edge, so the first period is whole
  assign clk_if.run = ~state_nxt[0];
  assign clk_if.div_sel = div_r;

  adc_clock_divider u_div (
    .clk_i(CLK_SYS_I),
    .resetn_i(RESETN_I),
    .clk_if(clk_if)
  );

  // register write decode
  assign wr_first = REG_WR_I && (REG_ADDR_I == OFS_CTRL_FIRST);
  assign wr_second = REG_WR_I && (REG_ADDR_I == OFS_CTRL_SECOND);
  assign wr_irq = REG_WR_I && (REG_ADDR_I == OFS_IRQ_CTRL);

  // start pulse edges seen through writes of the start bit
  assign start_rise = wr_first && !start_r && REG_WDATA_I[POS_START];
  assign start_fall = wr_first && start_r && !REG_WDATA_I[POS_START];

  // sample length depends on the selected source
  assign sample_last = (src_r == SRC_TEMP) ? SAMPLE_PERIODS_TEMP - 6'd1
                                           : SAMPLE_PERIODS - 6'd1;

  // control register next values
  always_comb begin
    ch_nxt = ch_r;
    align_nxt = align_r;
    power_nxt = power_r;
    start_nxt = start_r;
    src_nxt = src_r;
    ref_nxt = ref_r;
    div_nxt = div_r;
    gie_nxt = gie_r;
    cie_nxt = cie_r;
    temp_sensor_power_nxt = temp_sensor_power_r;
    option_map_control_nxt = option_map_control_r;
    if (wr_first) begin
      ch_nxt = REG_WDATA_I[3:0];
      align_nxt = REG_WDATA_I[POS_ALIGN];
      power_nxt = REG_WDATA_I[POS_POWER];
      start_nxt = REG_WDATA_I[POS_START];
    end
    if (wr_second) begin
      if (REG_WDATA_I[POS_SRC_LSB +: 3] != SRC_FORBIDDEN) begin
        src_nxt = REG_WDATA_I[POS_SRC_LSB +: 3];
      end
      ref_nxt = REG_WDATA_I[POS_REF_LSB +: 2];
      div_nxt = REG_WDATA_I[POS_DIV_LSB +: 3];
    end
    if (wr_irq) begin
      gie_nxt = REG_WDATA_I[POS_GIE];
      cie_nxt = REG_WDATA_I[POS_CIE];
      temp_sensor_power_nxt = REG_WDATA_I[POS_TEMP_SENSOR_POWER];
    end
    if (REG_WR_I && (REG_ADDR_I == OFS_OPTION_MAP)) begin
      option_map_control_nxt = REG_WDATA_I[POS_OPTION_MAP_CONTROL_EN];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ch_r <= RST_CTRL_FIRST[3:0];
      align_r <= RST_CTRL_FIRST[POS_ALIGN];
      power_r <= RST_CTRL_FIRST[POS_POWER];
      start_r <= RST_CTRL_FIRST[POS_START];
      src_r <= RST_CTRL_SECOND[POS_SRC_LSB +: 3];
      ref_r <= RST_CTRL_SECOND[POS_REF_LSB +: 2];
      div_r <= RST_CTRL_SECOND[POS_DIV_LSB +: 3];
      gie_r <= 1'b0;
      cie_r <= 1'b0;
      temp_sensor_power_r <= 1'b0;
      option_map_control_r <= 1'b0;
    end else begin
      ch_r <= ch_nxt;
      align_r <= align_nxt;
      power_r <= power_nxt;
      start_r <= start_nxt;
      src_r <= src_nxt;
      ref_r <= ref_nxt;
      div_r <= div_nxt;
      gie_r <= gie_nxt;
      cie_r <= cie_nxt;
      temp_sensor_power_r <= temp_sensor_power_nxt;
      option_map_control_r <= option_map_control_nxt;
    end
  end

  // sequencer: idle, sample, convert, counted in conversion clock ticks
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    result_nxt = result_r;
    done = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 6'd0;
        if (start_fall && power_nxt) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (clk_if.tick) begin
          if (cnt_r == sample_last) begin
            state_nxt = ST_CONVERT;
            cnt_nxt = 6'd0;
          end else begin
            cnt_nxt = cnt_r + 6'd1;
          end
        end
      end
      ST_CONVERT: begin
        if (clk_if.tick) begin
          if (cnt_r == CONVERT_PERIODS - 6'd1) begin
            state_nxt = ST_IDLE;
            cnt_nxt = 6'd0;
            result_nxt = ADC_CODE_I;
            done = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 6'd1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 6'd0;
      end
    endcase
    // power off or a new rising start resets the converter mid-run
    if (!state_r[0] && (!power_nxt || start_rise)) begin
      state_nxt = ST_IDLE;
      cnt_nxt = 6'd0;
      result_nxt = result_r;
      done = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'd0;
      result_r <= RST_RESULT;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
    end
  end

  // completion flag and interrupt; completion wins over a software clear
  always_comb begin
    flag_nxt = flag_r;
    if (wr_irq) begin
      flag_nxt = REG_WDATA_I[POS_FLAG];
    end
    if (done) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = flag_nxt && gie_nxt && cie_nxt;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
    end
  end

  // result formatting across the byte pair
  always_comb begin
    if (align_r) begin
      res_high = {4'h0, result_r[11:8]};
      res_low = result_r[7:0];
    end else begin
      res_high = result_r[11:4];
      res_low = {result_r[3:0], 4'h0};
    end
  end

  // read data, present only in the cycle after the read strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFS_CTRL_FIRST: rdata_nxt = {start_r, ~state_r[0], power_r, align_r, ch_r};
        OFS_CTRL_SECOND: rdata_nxt = {src_r, ref_r, div_r};
        OFS_RESULT_HIGH: rdata_nxt = res_high;
        OFS_RESULT_LOW: rdata_nxt = res_low;
        OFS_IRQ_CTRL: rdata_nxt = {4'h0, temp_sensor_power_r, flag_r, cie_r, gie_r};
        OFS_CAL_HIGH: rdata_nxt = CAL_HIGH;
        OFS_CAL_LOW: rdata_nxt = {CAL_LOW[7:4], 4'h0};
        OFS_OPTION_MAP: rdata_nxt = {7'h00, option_map_control_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // analog steering: pins, reference, power
  always_comb begin
    pin_nxt = 9'h000;
    if (power_r && ((src_r == SRC_EXT_A) || (src_r == SRC_EXT_B))) begin
      if ((ch_r <= CH_LAST_HIGH) && (ch_r != CH_ABSENT)) begin
        pin_nxt = 9'(9'h001 << ch_r);
      end
    end
    case (ref_r)
      REF_PIN: refsel_nxt = 3'b001;
      REF_TEMP: refsel_nxt = 3'b100;
      default: refsel_nxt = 3'b010; // analog supply for 01 and 11
    endcase
  end

  // option memory contents on the last program page
  assign opt_mem[0] = T2_CODE;
  assign opt_mem[1] = ADC2_CODE[11:4];
  assign opt_mem[2] = {ADC2_CODE[3:0], 4'h0};

  // table read answers only while the mapping is enabled
  always_comb begin
    tbl_nxt = 8'h00;
    hit_nxt = 1'b0;
    if (TBL_RD_I && option_map_control_r) begin
      case (TBL_ADDR_I)
        OPT_T2_ADDR: tbl_nxt = opt_mem[0];
        OPT_ADC2_HI_ADDR: tbl_nxt = opt_mem[1];
        OPT_ADC2_LO_ADDR: tbl_nxt = opt_mem[2];
        default: tbl_nxt = 8'h00;
      endcase
      hit_nxt = (TBL_ADDR_I >= OPT_T2_ADDR) && (TBL_ADDR_I <= OPT_ADC2_LO_ADDR);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_r <= 8'h00;
      pin_r <= 9'h000;
      refsel_r <= 3'b000;
      tbl_r <= 8'h00;
      hit_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      pin_r <= pin_nxt;
      refsel_r <= refsel_nxt;
      tbl_r <= tbl_nxt;
      hit_r <= hit_nxt;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA_O = rdata_r;
  assign IRQ_O = irq_r;
  assign ADC_POWER_O = power_r;
  assign SAMPLE_O = state_r[1];
  assign CONVERT_O = state_r[2];
  assign INPUT_SRC_O = src_r;
  assign PIN_SEL_O = pin_r;
  assign REF_SEL_O = refsel_r;
  assign TEMP_SENSOR_EN_O = temp_sensor_power_r;
  assign TBL_DATA_O = tbl_r;
  assign TBL_HIT_O = hit_r;

endmodule // adc_conversion_sequencer

/* File: pkg/adc_seq_pkg.sv */
/*
  constants shared by the converter sequencer and its clock divider:
  register offsets, field positions, reset values, phase lengths and codes.
  assumes an 8-bit register port with an 8-bit address.
*/
package adc_seq_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h01;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h02;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h03;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h04;
  localparam logic [7:0] OFS_CAL_HIGH = 8'h05;
  localparam logic [7:0] OFS_CAL_LOW = 8'h06;
  localparam logic [7:0] OFS_OPTION_MAP = 8'h07;

  // converter_control_first fields
  localparam int POS_START = 7;
  localparam int POS_BUSY = 6;
  localparam int POS_POWER = 5;
  localparam int POS_ALIGN = 4;
  // converter_control_second fields
  localparam int POS_SRC_LSB = 5;
  localparam int POS_REF_LSB = 3;
  localparam int POS_DIV_LSB = 0;
  // irq control fields, then the option map enable
  localparam int POS_GIE = 0;
  localparam int POS_CIE = 1;
  localparam int POS_FLAG = 2;
  localparam int POS_TEMP_SENSOR_POWER = 3;
  localparam int POS_OPTION_MAP_CONTROL_EN = 0;

  // reset values
  localparam logic [7:0] RST_CTRL_FIRST = 8'h00;
  localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;

  // input source and reference codes
  localparam logic [2:0] SRC_EXT_A = 3'b000;
  localparam logic [2:0] SRC_TEMP = 3'b010;
  localparam logic [2:0] SRC_EXT_B = 3'b110;
  localparam logic [2:0] SRC_FORBIDDEN = 3'b111;
  localparam logic [1:0] REF_PIN = 2'b00;
  localparam logic [1:0] REF_TEMP = 2'b10;
  localparam logic [3:0] CH_LAST_LOW = 4'h3;
  localparam logic [3:0] CH_ABSENT = 4'h4;
  localparam logic [3:0] CH_LAST_HIGH = 4'h8;
  localparam int PIN_COUNT = 9;

  // phase lengths in conversion clock periods
  localparam logic [5:0] SAMPLE_PERIODS = 6'd4;
  localparam logic [5:0] SAMPLE_PERIODS_TEMP = 6'd46;
  localparam logic [5:0] CONVERT_PERIODS = 6'd12;
  localparam int RESULT_WIDTH = 12;

  // option memory mapping on the last program page
  localparam logic [13:0] OPT_T2_ADDR = 14'h3FF5;
  localparam logic [13:0] OPT_ADC2_HI_ADDR = 14'h3FF6;
  localparam logic [13:0] OPT_ADC2_LO_ADDR = 14'h3FF7;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } seq_state_t;

endpackage

/* File: pkg/adc_clk_if.sv */
/*
  carrier between the sequencer and its conversion clock divider.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface adc_clk_if;
  logic run;
  logic [2:0] div_sel;
  logic tick;
  // sequencer end
  modport ctrl (output run, output div_sel, input tick);
  // divider end
  modport gen (input run, input div_sel, output tick);
endinterface

/* File: hdl/adc_clock_divider.sv */
/*
  conversion clock divider: one tick every 2**div_sel system clocks while run.
  assumes run and div_sel are stable synchronous levels.
*/
`timescale 1ns/100ps
module adc_clock_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // sequencer side
  adc_clk_if.gen clk_if
);
  import adc_seq_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [6:0] limit;

  // divide by a power of two, restart whenever the sequencer idles
  always_comb begin
    limit = 7'((8'h01 << clk_if.div_sel) - 8'h01);
    cnt_nxt = 7'h00;
    tick_nxt = 1'b0;
    if (clk_if.run) begin
      if (cnt_r >= limit) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 7'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign clk_if.tick = tick_r;

endmodule // adc_clock_divider

/* File: verification/adc_seq_assertions.sv */
/*
  checker for the converter sequencer: phase lengths, start, abort, irq, steering.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module adc_seq_assertions (
  // clock, reset and register port
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  // converter outputs
  input wire logic IRQ_O,
  input wire logic ADC_POWER_O,
  input wire logic SAMPLE_O,
  input wire logic CONVERT_O,
  input wire logic [2:0] INPUT_SRC_O,
  input wire logic [adc_seq_pkg::PIN_COUNT-1:0] PIN_SEL_O,
  input wire logic [2:0] REF_SEL_O
);
  import adc_seq_pkg::*;
  logic [2:0] div_r, div_nxt;
  logic [1:0] en_r, en_nxt;
  logic [12:0] s_r, s_nxt, c_r, c_nxt, s_len;
  // shadows of divider and irq enables, phase cycle counts
  always_comb begin
    div_nxt = (REG_WR_I && REG_ADDR_I == OFS_CTRL_SECOND) ? REG_WDATA_I[2:0] : div_r;
    en_nxt = (REG_WR_I && REG_ADDR_I == OFS_IRQ_CTRL) ? REG_WDATA_I[1:0] : en_r;
    s_nxt = SAMPLE_O ? s_r + 13'd1 : 13'd0;
    c_nxt = CONVERT_O ? c_r + 13'd1 : 13'd0;
  end
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_r <= 3'd0;
      en_r <= 2'd0;
      s_r <= 13'd0;
      c_r <= 13'd0;
    end else begin
      div_r <= div_nxt;
      en_r <= en_nxt;
      s_r <= s_nxt;
      c_r <= c_nxt;
    end
  end
  assign s_len = ((INPUT_SRC_O == SRC_TEMP) ? 13'd46 : 13'd4) << div_r;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_sample_done;
    $fell(SAMPLE_O) && CONVERT_O;
  endsequence
  sequence s_conv_done;
    $fell(CONVERT_O) && ADC_POWER_O;
  endsequence
  sequence s_power_off;
    REG_WR_I && REG_ADDR_I == OFS_CTRL_FIRST && !REG_WDATA_I[POS_POWER];
  endsequence
  a_sample_len: assert property (s_sample_done |-> s_r == s_len)
    else $error("sample phase length wrong");
  a_convert_len: assert property (s_conv_done |-> c_r == (13'd12 << div_r))
    else $error("convert phase length wrong");
  a_start_launch: assert property ($rose(SAMPLE_O) |->
    $past(REG_WR_I && REG_ADDR_I == OFS_CTRL_FIRST && !REG_WDATA_I[POS_START]))
    else $error("sampling began without start fall");
  a_abort_idle: assert property (CONVERT_O ##0 s_power_off |=> !CONVERT_O && !IRQ_O)
    else $error("power off did not abort quietly");
  a_irq_done: assert property (s_conv_done ##0 en_r == 2'b11 |-> IRQ_O)
    else $error("no irq at completion");
  a_busy_read: assert property (REG_RD_I && REG_ADDR_I == OFS_CTRL_FIRST |=>
    REG_RDATA_O[POS_BUSY] == $past(SAMPLE_O || CONVERT_O))
    else $error("busy bit disagrees with phase");
  a_src_forbidden: assert property (REG_WR_I && REG_ADDR_I == OFS_CTRL_SECOND &&
    REG_WDATA_I[7:5] == SRC_FORBIDDEN |=> $stable(INPUT_SRC_O))
    else $error("forbidden source accepted");
  a_ref_decode: assert property (REG_WR_I && REG_ADDR_I == OFS_CTRL_SECOND |-> ##2
    REF_SEL_O == (($past(REG_WDATA_I[4:3], 2) == REF_PIN) ? 3'b001 :
    ($past(REG_WDATA_I[4:3], 2) == REF_TEMP) ? 3'b100 : 3'b010))
    else $error("reference steering wrong");
  a_pin_onehot: assert property ($onehot0(PIN_SEL_O) && !PIN_SEL_O[4])
    else $error("pin steering not one-hot");
endmodule // adc_seq_assertions

bind adc_conversion_sequencer adc_seq_assertions i_adc_seq_assertions (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .IRQ_O(IRQ_O), .ADC_POWER_O(ADC_POWER_O),
  .SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O), .INPUT_SRC_O(INPUT_SRC_O),
  .PIN_SEL_O(PIN_SEL_O), .REF_SEL_O(REF_SEL_O));

/* File: verification/testbench.sv */
/*
  register-level testbench of the converter sequencer.
  assumes the checker is bound separately; the bench plays the analog core.
*/
`timescale 1ns/100ps
module testbench;
  import adc_seq_pkg::*;
  localparam logic [7:0] CAL_H = 8'h9A; // arbitrary factory value
  localparam logic [7:0] CAL_L = 8'hE0; // arbitrary factory value
  localparam logic [7:0] T2 = 8'h5C; // arbitrary factory value
  localparam logic [11:0] ADC2 = 12'h7D3; // arbitrary factory value
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, tbl_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, tbl_data;
  logic [11:0] adc_code = 0;
  logic [13:0] tbl_addr = 0;
  logic irq, adc_power, sample, convert, temp_en, tbl_hit;
  logic [2:0] input_src, ref_sel;
  logic [8:0] pin_sel;
  int error_cnt = 0, checks_done = 0, cyc = 0, s_cnt = 0, c_cnt = 0;

  adc_conversion_sequencer #(.CAL_HIGH(CAL_H), .CAL_LOW(CAL_L), .T2_CODE(T2),
    .ADC2_CODE(ADC2)) i_adc_conversion_sequencer (
    .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_RDATA_O(reg_rdata), .IRQ_O(irq), .ADC_CODE_I(adc_code),
    .ADC_POWER_O(adc_power), .SAMPLE_O(sample), .CONVERT_O(convert),
    .INPUT_SRC_O(input_src), .PIN_SEL_O(pin_sel), .REF_SEL_O(ref_sel),
    .TEMP_SENSOR_EN_O(temp_en), .TBL_RD_I(tbl_rd), .TBL_ADDR_I(tbl_addr),
    .TBL_DATA_O(tbl_data), .TBL_HIT_O(tbl_hit));

  always #20 clk_sys = ~clk_sys;
  // phase cycle counts and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    s_cnt <= s_cnt + int'(sample === 1'b1);
    c_cnt <= c_cnt + int'(convert === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(12'(reg_rdata), 12'(exp));
  endtask
  task automatic tbl(input logic [13:0] a, input logic [8:0] exp);
    @(posedge clk_sys);
    tbl_addr <= a;
    tbl_rd <= 1'b1;
    @(posedge clk_sys);
    tbl_rd <= 1'b0;
    #1 chk({3'b000, tbl_hit, tbl_data}, 12'(exp));
  endtask
  task automatic launch(input logic [7:0] c0);
    wr(OFS_CTRL_FIRST, c0);
    wr(OFS_CTRL_FIRST, c0 | 8'h80);
    wr(OFS_CTRL_FIRST, c0);
  endtask
  // full conversion with measured phase lengths
  task automatic conv(input logic [7:0] c0, input int sl, input int cl);
    int s0, c0n, n;
    launch(c0);
    #1 s0 = s_cnt;
    c0n = c_cnt;
    rdc(OFS_CTRL_FIRST, c0 | 8'h40);
    n = 0;
    while ((sample === 1'b1 || convert === 1'b1) && n < 9000) begin
      settle();
      n++;
    end
    chk(12'(s_cnt - s0), 12'(sl));
    chk(12'(c_cnt - c0n), 12'(cl));
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values, factory bytes, unmapped place
    for (int a = 0; a < 8; a++) begin
      rdc(a[7:0], a == 5 ? CAL_H : a == 6 ? {CAL_L[7:4], 4'h0} : 8'h00);
    end
    rdc(8'h3F, 8'h00);
    wr(OFS_CTRL_SECOND, 8'h08);
    wr(OFS_CTRL_SECOND, 8'hF3);
    rdc(OFS_CTRL_SECOND, 8'h13);
    chk(input_src, SRC_EXT_A);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CTRL_SECOND, 8'(r << 3));
      settle();
      chk(ref_sel, r == 0 ? 3'b001 : r == 2 ? 3'b100 : 3'b010);
    end
    for (int n = 0; n < 16; n++) begin
      wr(OFS_CTRL_FIRST, 8'h20 | 8'(n));
      settle();
      chk(pin_sel, (n < 9 && n != 4) ? 9'(1 << n) : 9'h000);
    end
    chk(adc_power, 1'b1);
    wr(OFS_IRQ_CTRL, 8'h03);
    for (int dv = 0; dv < 8; dv++) begin
      wr(OFS_CTRL_SECOND, 8'h08 | 8'(dv));
      adc_code <= {1'b1, dv[2:0], 8'h5C};
      conv(8'h20, 4 << dv, 12 << dv);
      chk(irq, 1'b1);
      rdc(OFS_IRQ_CTRL, 8'h07);
      rdc(OFS_RESULT_HIGH, {1'b1, dv[2:0], 4'h5});
      rdc(OFS_RESULT_LOW, 8'hC0);
      wr(OFS_IRQ_CTRL, 8'h03);
      chk(irq, 1'b0);
    end
    wr(OFS_CTRL_FIRST, 8'h30);
    rdc(OFS_RESULT_HIGH, 8'h0F);
    rdc(OFS_RESULT_LOW, 8'h5C);
    // only the global enable set: flag without interrupt
    wr(OFS_IRQ_CTRL, 8'h01);
    wr(OFS_CTRL_SECOND, 8'h08);
    adc_code <= 12'h123;
    conv(8'h30, 4, 12);
    chk(irq, 1'b0);
    rdc(OFS_IRQ_CTRL, 8'h05);
    rdc(OFS_RESULT_LOW, 8'h23);
    // temperature input: park channel, then select source
    wr(OFS_CTRL_FIRST, 8'h2C);
    wr(OFS_CTRL_SECOND, 8'h50);
    wr(OFS_IRQ_CTRL, 8'h0B);
    adc_code <= 12'h9E7;
    conv(8'h2C, 46, 12);
    chk({temp_en, irq, input_src}, {2'b11, SRC_TEMP});
    wr(OFS_IRQ_CTRL, 8'h03);
    // power off mid-conversion
    wr(OFS_CTRL_SECOND, 8'h08);
    adc_code <= 12'h456;
    launch(8'h20);
    repeat (10) @(posedge clk_sys);
    wr(OFS_CTRL_FIRST, 8'h00);
    settle();
    chk({adc_power, sample, convert, irq}, 4'h0);
    rdc(OFS_CTRL_FIRST, 8'h00);
    rdc(OFS_IRQ_CTRL, 8'h03);
    rdc(OFS_RESULT_HIGH, 8'h9E);
    // option page reads, unmapped then mapped
    tbl(OPT_T2_ADDR, 9'h000);
    wr(OFS_OPTION_MAP, 8'h01);
    tbl(OPT_T2_ADDR, {1'b1, T2});
    tbl(OPT_ADC2_HI_ADDR, {1'b1, ADC2[11:4]});
    tbl(OPT_ADC2_LO_ADDR, {1'b1, ADC2[3:0], 4'h0});
    tbl(14'h3FF4, 9'h000);
    stop_test();
  end
endmodule // testbench
